// >>> core/crf_cpu_regs_flags_reset.sv
// crf_cpu_regs_flags_reset: cpu registers, flags, pc, stack pointer and reset values
`default_nettype none

module crf_cpu_regs_flags_reset (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sequencer command
  input wire logic opValid,
  input wire crf_pkg::crf_op_t opCode,
  input wire logic [crf_pkg::NIB_W-1:0] opData,
  input wire logic aluCarry,
  input wire logic aluStatus,
  input wire logic [3:0] opBit,
  input wire logic [crf_pkg::PC_W-1:0] pcTarget,
  input wire crf_pkg::crf_frame_t pullFrame,
  // hardware interrupt events
  input wire logic [crf_pkg::IRQ_N-1:0] irqEvent,
  // register port
  input wire logic [crf_pkg::ADDR_W-1:0] regAddr,
  input wire logic [crf_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [crf_pkg::DATA_W-1:0] regRdData,
  // working registers
  output logic [crf_pkg::NIB_W-1:0] accOut,
  output logic [crf_pkg::NIB_W-1:0] secondOut,
  output logic [crf_pkg::PAGE_W-1:0] pageOut,
  output logic [crf_pkg::NIB_W-1:0] colIdxOut,
  output logic [crf_pkg::NIB_W-1:0] rowIdxOut,
  output logic [crf_pkg::NIB_W-1:0] colAuxOut,
  output logic [crf_pkg::NIB_W-1:0] rowAuxOut,
  output logic [9:0] ramAddr,
  output logic [15:0] dPortSel,
  // flags, pc and stack
  output logic carryOut,
  output logic statusOut,
  output logic [crf_pkg::PC_W-1:0] pcOut,
  output logic fetchEn,
  output logic [crf_pkg::SP_W-1:0] spOut,
  output logic pushStrobe,
  output crf_pkg::crf_frame_t pushFrame,
  // interrupt control bits
  output logic irqEnable,
  output logic [crf_pkg::IRQ_N-1:0] irqFlags,
  output logic [crf_pkg::IRQ_N-1:0] irqMasks,
  // peripheral reset values
  output logic [crf_pkg::INIT_DEPTH-1:0][crf_pkg::NIB_W-1:0] initRegs
);
  // one-hot pick of a control bit or a d port line
  function automatic logic [15:0] crf_onehot(input logic [3:0] idx);
    crf_onehot = 16'h0001 << idx;
  endfunction : crf_onehot

  logic [3:0] acc_reg, acc_next;
  logic [3:0] second_reg, second_next;
  logic [1:0] page_reg, page_next;
  logic [3:0] col_reg, col_next;
  logic [3:0] row_reg, row_next;
  logic [3:0] colAux_reg, colAux_next;
  logic [3:0] rowAux_reg, rowAux_next;
  logic carry_reg, carry_next;
  logic status_reg, status_next;
  logic [13:0] pc_reg, pc_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] rdData_reg, rdData_next;
  logic [9:0] ramAddr_reg;
  logic [15:0] dPortSel_reg;
  logic fetchEn_reg;
  logic pushStrobe_reg;
  crf_pkg::crf_frame_t pushFrame_reg;
  logic [crf_pkg::SP_W-1:0] spWire;

  // sequencer decode; nothing moves before the first fetch after reset
  wire opGo = opValid && fetchEn_reg;
  wire isLdA = opGo && opCode == crf_pkg::OP_LD_A;
  wire isLdB = opGo && opCode == crf_pkg::OP_LD_B;
  wire isLdW = opGo && opCode == crf_pkg::OP_LD_W;
  wire isLdX = opGo && opCode == crf_pkg::OP_LD_X;
  wire isLdY = opGo && opCode == crf_pkg::OP_LD_Y;
  wire isLdSpx = opGo && opCode == crf_pkg::OP_LD_SPX;
  wire isLdSpy = opGo && opCode == crf_pkg::OP_LD_SPY;
  wire isXchX = opGo && opCode == crf_pkg::OP_XCH_X;
  wire isXchY = opGo && opCode == crf_pkg::OP_XCH_Y;
  wire isArith = opGo && opCode == crf_pkg::OP_ARITH;
  wire isCmp = opGo && opCode == crf_pkg::OP_CMP;
  wire isTest = opGo && opCode == crf_pkg::OP_TEST;
  wire isSec = opGo && opCode == crf_pkg::OP_SEC;
  wire isRec = opGo && opCode == crf_pkg::OP_REC;
  wire isRotl = opGo && opCode == crf_pkg::OP_ROTATE_LEFT_INSTR;
  wire isRotr = opGo && opCode == crf_pkg::OP_ROTATE_RIGHT_INSTR;
  wire isBranch = opGo && opCode == crf_pkg::OP_BRANCH;
  wire isCall = opGo && opCode == crf_pkg::OP_CALL;
  wire isJump = opGo && opCode == crf_pkg::OP_JUMP;
  wire isRtn = opGo && opCode == crf_pkg::OP_RTN;
  wire isRtni = opGo && opCode == crf_pkg::OP_RETURN_FROM_INTERRUPT;
  wire isIrq = opGo && opCode == crf_pkg::OP_IRQ;
  wire isSem = opGo && opCode == crf_pkg::OP_SEM;
  wire isRem = opGo && opCode == crf_pkg::OP_REM;
  wire isTm = opGo && opCode == crf_pkg::OP_TM;

  // conditional transfers take the status flag as their condition
  wire condTaken = status_reg;
  wire branchTaken = isBranch && condTaken;
  wire callTaken = isCall && condTaken;
  wire doPush = callTaken || isIrq;
  wire doPull = isRtn || isRtni;

  // register port decode; sequencer writes win over a port write
  wire wrAcc = regWr && regAddr == crf_pkg::REG_ACC;
  wire wrSecond = regWr && regAddr == crf_pkg::REG_SECOND;
  wire wrPage = regWr && regAddr == crf_pkg::REG_PAGE;
  wire wrCol = regWr && regAddr == crf_pkg::REG_COL;
  wire wrRow = regWr && regAddr == crf_pkg::REG_ROW;
  wire wrColAux = regWr && regAddr == crf_pkg::REG_COL_AUX;
  wire wrRowAux = regWr && regAddr == crf_pkg::REG_ROW_AUX;
  wire wrFlags = regWr && regAddr == crf_pkg::REG_FLAGS;
  wire wrCtrl = regWr && regAddr == crf_pkg::REG_CTRL;
  wire inInit = regAddr[7:5] == crf_pkg::REG_INIT_BASE[7:5];
  wire [4:0] initIdx = regAddr[4:0];
  wire initHit = inInit && initIdx < 5'(crf_pkg::INIT_DEPTH);
  wire wrInit = regWr && initHit;

  // accumulator and second register
  assign acc_next = isRotl ? {acc_reg[2:0], carry_reg} :
                    isRotr ? {carry_reg, acc_reg[3:1]} :
                    (isLdA || isArith) ? opData :
                    wrAcc ? regWrData[3:0] : acc_reg;
  assign second_next = isLdB ? opData :
                       wrSecond ? regWrData[3:0] : second_reg;

  // indirect address registers and their aux partners
  assign page_next = isLdW ? opData[1:0] :
                     wrPage ? regWrData[1:0] : page_reg;
  assign col_next = isLdX ? opData :
                    isXchX ? colAux_reg :
                    wrCol ? regWrData[3:0] : col_reg;
  assign row_next = isLdY ? opData :
                    isXchY ? rowAux_reg :
                    wrRow ? regWrData[3:0] : row_reg;
  assign colAux_next = isLdSpx ? opData :
                       isXchX ? col_reg :
                       wrColAux ? regWrData[3:0] : colAux_reg;
  assign rowAux_next = isLdSpy ? opData :
                       isXchY ? row_reg :
                       wrRowAux ? regWrData[3:0] : rowAux_reg;

  // carry: plain return leaves it alone, interrupt return restores it
  assign carry_next = isArith ? aluCarry :
                      isSec ? 1'h1 :
                      isRec ? 1'h0 :
                      isRotl ? acc_reg[3] :
                      isRotr ? acc_reg[0] :
                      isRtni ? pullFrame.carry :
                      wrFlags ? regWrData[0] : carry_reg;

  // status: latched by alu results and memory-bit tests, forced high after a conditional
  // transfer whether taken or skipped, restored by interrupt return, otherwise held; not writable by port
  wire ctrlBitVal = |(ctrl_reg & crf_onehot(opBit));
  assign status_next = (isArith || isCmp || isTest) ? aluStatus :
                       isTm ? ctrlBitVal :
                       (isBranch || isCall) ? 1'h1 :
                       isRtni ? pullFrame.status :
                       status_reg;

  // program counter: step by one per accepted command unless a transfer loads it
  wire [13:0] pcStep = pc_reg + 14'h0001;
  assign pc_next = (branchTaken || callTaken || isJump) ? pcTarget :
                   isIrq ? pcTarget :
                   doPull ? pullFrame.pc :
                   opGo ? pcStep : pc_reg;

  // control bits: software may clear request flags but never set them;
  // a hardware event in the same cycle as a clear wins
  wire [15:0] bitSel = crf_onehot(opBit);
  wire [15:0] swSet = isSem ? (bitSel & ~crf_pkg::CB_IF_MASK) : 16'h0000;
  wire [15:0] swClr = isRem ? bitSel : 16'h0000;
  wire [15:0] portCtrl = (regWrData & ~crf_pkg::CB_IF_MASK) |
                         (regWrData & ctrl_reg & crf_pkg::CB_IF_MASK);
  wire [15:0] ctrlBase = (isSem || isRem) ? ctrl_reg : wrCtrl ? portCtrl : ctrl_reg;
  wire [15:0] hwSet = 16'(irqEvent) << crf_pkg::CB_IF0;
  assign ctrl_next = ((((ctrlBase | swSet) & ~swClr) | hwSet) & crf_pkg::CB_USED);

  // clearing the stack reset bit by a memory-bit clear reloads the pointer
  wire spReload = isRem && opBit == 4'(crf_pkg::CB_RSP);

  // stack pointer with its fixed bits
  crf_stack_ptr u_stack (
    .mclk(mclk),
    .rst(rst),
    .push(doPush),
    .pull(doPull),
    .reload(spReload),
    .sp(spWire)
  );

  // peripheral nibbles, all but 15 and 21 loaded with their reset values
  crf_init_regs #(
    .DEPTH(crf_pkg::INIT_DEPTH)
  ) u_init (
    .mclk(mclk),
    .rst(rst),
    .wrEn(wrInit),
    .wrIdx(initIdx),
    .wrData(regWrData[3:0]),
    .nibbles(initRegs)
  );

  // read selection, answered one cycle after the strobe
  always_comb begin
    case (regAddr)
      crf_pkg::REG_ACC: rdData_next = {12'h000, acc_reg};
      crf_pkg::REG_SECOND: rdData_next = {12'h000, second_reg};
      crf_pkg::REG_PAGE: rdData_next = {14'h0000, page_reg};
      crf_pkg::REG_COL: rdData_next = {12'h000, col_reg};
      crf_pkg::REG_ROW: rdData_next = {12'h000, row_reg};
      crf_pkg::REG_COL_AUX: rdData_next = {12'h000, colAux_reg};
      crf_pkg::REG_ROW_AUX: rdData_next = {12'h000, rowAux_reg};
      crf_pkg::REG_FLAGS: rdData_next = {14'h0000, status_reg, carry_reg};
      crf_pkg::REG_PC: rdData_next = {2'h0, pc_reg};
      crf_pkg::REG_SP: rdData_next = {6'h00, spWire};
      crf_pkg::REG_CTRL: rdData_next = ctrl_reg;
      default: rdData_next = initHit ? {12'h000, initRegs[initIdx]} : crf_pkg::RD_UNMAPPED;
    endcase
  end

  // working registers; reset clears them to zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_reg <= 4'h0;
      second_reg <= 4'h0;
      page_reg <= 2'h0;
      col_reg <= 4'h0;
      row_reg <= 4'h0;
      colAux_reg <= 4'h0;
      rowAux_reg <= 4'h0;
      carry_reg <= 1'h0;
    end else begin
      acc_reg <= acc_next;
      second_reg <= second_next;
      page_reg <= page_next;
      col_reg <= col_next;
      row_reg <= row_next;
      colAux_reg <= colAux_next;
      rowAux_reg <= rowAux_next;
      carry_reg <= carry_next;
    end
  end

  // status, pc and control bits with their documented reset values
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_reg <= crf_pkg::ST_RESET;
      pc_reg <= crf_pkg::PC_RESET;
      ctrl_reg <= crf_pkg::CB_RESET;
      fetchEn_reg <= 1'h0;
    end else begin
      status_reg <= status_next;
      pc_reg <= pc_next;
      ctrl_reg <= ctrl_next;
      fetchEn_reg <= 1'h1;
    end
  end

  // pushed frame: return address for a call, current pc for an interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      pushStrobe_reg <= 1'h0;
      pushFrame_reg <= '0;
    end else begin
      pushStrobe_reg <= doPush;
      if (doPush) begin
        pushFrame_reg.pc <= isIrq ? pc_reg : pcStep;
        pushFrame_reg.carry <= carry_reg;
        pushFrame_reg.status <= status_reg;
      end
    end
  end

  // registered address views so every output leaves a flip-flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      ramAddr_reg <= 10'h000;
      dPortSel_reg <= 16'h0001;
      rdData_reg <= crf_pkg::RD_UNMAPPED;
    end else begin
      ramAddr_reg <= {page_next, col_next, row_next};
      dPortSel_reg <= crf_onehot(row_next);
      rdData_reg <= regRd ? rdData_next : crf_pkg::RD_UNMAPPED;
    end
  end

  assign accOut = acc_reg;
  assign secondOut = second_reg;
  assign pageOut = page_reg;
  assign colIdxOut = col_reg;
  assign rowIdxOut = row_reg;
  assign colAuxOut = colAux_reg;
  assign rowAuxOut = rowAux_reg;
  assign ramAddr = ramAddr_reg;
  assign dPortSel = dPortSel_reg;
  assign carryOut = carry_reg;
  assign statusOut = status_reg;
  assign pcOut = pc_reg;
  assign fetchEn = fetchEn_reg;
  assign spOut = spWire;
  assign pushStrobe = pushStrobe_reg;
  assign pushFrame = pushFrame_reg;
  assign irqEnable = ctrl_reg[crf_pkg::CB_IE];
  assign irqFlags = ctrl_reg[crf_pkg::CB_IF0 +: crf_pkg::IRQ_N];
  assign irqMasks = ctrl_reg[crf_pkg::CB_IM0 +: crf_pkg::IRQ_N];
  assign regRdData = rdData_reg;
endmodule : crf_cpu_regs_flags_reset

`default_nettype wire

// >>> core/crf_init_regs.sv
// crf_init_regs: peripheral nibble registers; those with their INIT_MASK bit set take their values at reset
`default_nettype none

module crf_init_regs #(
  parameter int DEPTH = crf_pkg::INIT_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write port
  input wire logic wrEn,
  input wire logic [crf_pkg::INIT_IDX_W-1:0] wrIdx,
  input wire logic [crf_pkg::NIB_W-1:0] wrData,
  // contents
  output logic [DEPTH-1:0][crf_pkg::NIB_W-1:0] nibbles
);
  if (DEPTH != crf_pkg::INIT_DEPTH) begin : g_chk
    $error("crf_init_regs: depth must match the reset table");
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_nib
    // unmasked nibbles keep their old content through reset
    always_ff @(posedge mclk) begin
      if (rst && crf_pkg::INIT_MASK[i]) begin
        nibbles[i] <= crf_pkg::INIT_RESET[i*crf_pkg::NIB_W +: crf_pkg::NIB_W];
      end else if (!rst && wrEn && wrIdx == crf_pkg::INIT_IDX_W'(i)) begin
        nibbles[i] <= wrData;
      end
    end
  end
endmodule : crf_init_regs

`default_nettype wire

// >>> core/crf_pkg.sv
// crf_pkg: constants, types and register map of the cpu register and reset block
`default_nettype none

package crf_pkg;
  localparam int PC_W = 14;
  localparam int SP_W = 10;
  localparam int NIB_W = 4;
  localparam int PAGE_W = 2;
  localparam int LEVEL_W = 4;
  localparam int IRQ_N = 5;
  localparam int CB_N = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int INIT_DEPTH = 24;
  localparam int INIT_IDX_W = 5;

  // stack pointer layout: fixed top, level field, fixed low bits
  localparam logic [3:0] SP_TOP = 4'hF;
  localparam logic [1:0] SP_LOW = 2'h3;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'hF;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic ST_RESET = 1'h1;

  // control bit area positions
  localparam int CB_IE = 0;
  localparam int CB_IF0 = 1;
  localparam int CB_IM0 = 6;
  localparam int CB_RSP = 11;
  localparam logic [CB_N-1:0] CB_USED = 16'h0FFF;
  localparam logic [CB_N-1:0] CB_IF_MASK = 16'h003E;
  localparam logic [CB_N-1:0] CB_RESET = 16'h07C0;

  // register map, word addresses on the plain port
  localparam logic [ADDR_W-1:0] REG_ACC = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SECOND = 8'h01;
  localparam logic [ADDR_W-1:0] REG_PAGE = 8'h02;
  localparam logic [ADDR_W-1:0] REG_COL = 8'h03;
  localparam logic [ADDR_W-1:0] REG_ROW = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COL_AUX = 8'h05;
  localparam logic [ADDR_W-1:0] REG_ROW_AUX = 8'h06;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h07;
  localparam logic [ADDR_W-1:0] REG_PC = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SP = 8'h09;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h0A;
  localparam logic [ADDR_W-1:0] REG_INIT_BASE = 8'h20;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 16'h0000;

  // peripheral nibbles after reset; entry 0 is the low nibble
  // 0-2 port latches, 3-6 direction controls, 7-9 timer and serial modes,
  // 10-13 timer counters, 14/15 and 20/21 timer write lo/hi,
  // 16-18 prescaler, 19 octal counter, 22-23 spare mode nibbles
  localparam logic [INIT_DEPTH*NIB_W-1:0] INIT_RESET = 96'h000000000000000000000FFF;
  localparam logic [INIT_DEPTH-1:0] INIT_MASK = 24'hDF7FFF;

  // sequencer commands
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LD_A = 5'h01, OP_LD_B = 5'h02, OP_LD_W = 5'h03,
    OP_LD_X = 5'h04, OP_LD_Y = 5'h05, OP_LD_SPX = 5'h06, OP_LD_SPY = 5'h07,
    OP_XCH_X = 5'h08, OP_XCH_Y = 5'h09, OP_ARITH = 5'h0A, OP_CMP = 5'h0B,
    OP_TEST = 5'h0C, OP_SEC = 5'h0D, OP_REC = 5'h0E, OP_ROTATE_LEFT_INSTR = 5'h0F,
    OP_ROTATE_RIGHT_INSTR = 5'h10, OP_BRANCH = 5'h11, OP_CALL = 5'h12, OP_JUMP = 5'h13,
    OP_RTN = 5'h14, OP_RETURN_FROM_INTERRUPT = 5'h15, OP_IRQ = 5'h16, OP_SEM = 5'h17,
    OP_REM = 5'h18, OP_TM = 5'h19
  } crf_op_t;

  // one stack frame: return address and saved flags
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic carry;
    logic status;
  } crf_frame_t;
endpackage : crf_pkg

`default_nettype wire

// >>> core/crf_stack_ptr.sv
// crf_stack_ptr: sixteen-level stack pointer with fixed upper and lower bits
`default_nettype none

module crf_stack_ptr (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // stack moves
  input wire logic push,
  input wire logic pull,
  input wire logic reload,
  // pointer
  output logic [crf_pkg::SP_W-1:0] sp
);
  logic [crf_pkg::LEVEL_W-1:0] level_reg;
  logic [crf_pkg::LEVEL_W-1:0] level_next;

  // only the level field moves, so a step of one there is four on the pointer
  assign level_next = push ? level_reg - 4'h1 :
                      pull ? level_reg + 4'h1 : level_reg;

  // reload beats a simultaneous move
  always_ff @(posedge mclk) begin
    if (rst || reload) begin
      level_reg <= crf_pkg::LEVEL_RESET;
    end else begin
      level_reg <= level_next;
    end
  end

  assign sp = {crf_pkg::SP_TOP, level_reg, crf_pkg::SP_LOW};
endmodule : crf_stack_ptr

`default_nettype wire

// >>> verification/crf_cpu_regs_flags_reset_props.sv
// crf_cpu_regs_flags_reset_props: port-level checker for the cpu register block
`default_nettype none

module crf_cpu_regs_flags_reset_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sequencer side
  input wire logic opValid,
  input wire crf_pkg::crf_op_t opCode,
  input wire logic aluCarry,
  input wire logic [3:0] opBit,
  input wire logic [crf_pkg::PC_W-1:0] pcTarget,
  input wire crf_pkg::crf_frame_t pullFrame,
  input wire logic [crf_pkg::IRQ_N-1:0] irqEvent,
  // register port
  input wire logic [crf_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWr,
  // observed state
  input wire logic carryOut,
  input wire logic statusOut,
  input wire logic [crf_pkg::PC_W-1:0] pcOut,
  input wire logic fetchEn,
  input wire logic [crf_pkg::SP_W-1:0] spOut,
  input wire logic pushStrobe,
  input wire logic irqEnable,
  input wire logic [crf_pkg::IRQ_N-1:0] irqFlags,
  input wire logic [crf_pkg::IRQ_N-1:0] irqMasks
);
  default clocking @(posedge mclk);
  endclocking

  // accepted command; push excludes a full stack, since the design wraps there
  wire go;
  wire takenPush;
  assign go = opValid && fetchEn;
  assign takenPush = go && (opCode == crf_pkg::OP_IRQ || opCode == crf_pkg::OP_CALL && statusOut);

  property p_reset_load;
    rst |=> pcOut == 14'h0000 && statusOut && spOut == 10'h3FF && !fetchEn && !irqEnable
      && irqFlags == 5'h00 && irqMasks == 5'h1F;
  endproperty
  a_reset_load: assert property (p_reset_load) else $error("reset values wrong");
  property p_fetch_start;
    disable iff (rst) $fell(rst) |=> fetchEn && pcOut == 14'h0000;
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("fetch start wrong");
  property p_sp_frame;
    disable iff (rst) spOut[9:6] == 4'hF && spOut[1:0] == 2'h3;
  endproperty
  a_sp_frame: assert property (p_sp_frame) else $error("stack pointer fixed bits");
  property p_push;
    disable iff (rst) takenPush && spOut != 10'h3C3 |=> spOut == $past(spOut) - 10'h004
      && pushStrobe && pcOut == $past(pcTarget);
  endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_pull;
    disable iff (rst) go && opCode inside {crf_pkg::OP_RTN, crf_pkg::OP_RETURN_FROM_INTERRUPT}
      && spOut != 10'h3FF |=> spOut == $past(spOut) + 10'h004;
  endproperty
  a_pull: assert property (p_pull) else $error("pull step wrong");
  property p_branch_st;
    disable iff (rst) go && opCode inside {crf_pkg::OP_BRANCH, crf_pkg::OP_CALL} |=> statusOut;
  endproperty
  a_branch_st: assert property (p_branch_st) else $error("status not forced");
  property p_rtn_carry;
    disable iff (rst) go && opCode == crf_pkg::OP_RTN |=> $stable(carryOut);
  endproperty
  a_rtn_carry: assert property (p_rtn_carry) else $error("return moved carry");
  property p_return_from_interrupt;
    disable iff (rst) go && opCode == crf_pkg::OP_RETURN_FROM_INTERRUPT |=> carryOut == $past(pullFrame.carry)
      && statusOut == $past(pullFrame.status);
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("interrupt return flags");
  property p_arith_carry;
    disable iff (rst) go && opCode == crf_pkg::OP_ARITH |=> carryOut == $past(aluCarry);
  endproperty
  a_arith_carry: assert property (p_arith_carry) else $error("carry not latched");
  property p_st_hold;
    disable iff (rst) !go |=> $stable(statusOut);
  endproperty
  a_st_hold: assert property (p_st_hold) else $error("status moved");
  property p_sp_reload;
    disable iff (rst) go && opCode == crf_pkg::OP_REM && opBit == 4'hB |=> spOut == 10'h3FF;
  endproperty
  a_sp_reload: assert property (p_sp_reload) else $error("stack reload missing");
  property p_if_sw;
    disable iff (rst) (regWr && regAddr == crf_pkg::REG_CTRL || go && opCode == crf_pkg::OP_SEM)
      && irqEvent == 5'h00 |=> (irqFlags & ~$past(irqFlags)) == 5'h00;
  endproperty
  a_if_sw: assert property (p_if_sw) else $error("request flag set by software");
endmodule : crf_cpu_regs_flags_reset_props

bind crf_cpu_regs_flags_reset crf_cpu_regs_flags_reset_props props_u (
  .mclk, .rst, .opValid, .opCode, .aluCarry, .opBit, .pcTarget, .pullFrame, .irqEvent,
  .regAddr, .regWr, .carryOut, .statusOut, .pcOut, .fetchEn, .spOut, .pushStrobe,
  .irqEnable, .irqFlags, .irqMasks
);

`default_nettype wire

// >>> verification/crf_cpu_regs_flags_reset_tb.sv
// crf_cpu_regs_flags_reset_tb: directed bench for the cpu register block
`default_nettype none

module crf_cpu_regs_flags_reset_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic opValid = 1'b0;
  crf_pkg::crf_op_t opCode = crf_pkg::OP_NOP;
  logic [3:0] opData = 4'h0;
  logic aluCarry = 1'b0;
  logic aluStatus = 1'b0;
  logic [3:0] opBit = 4'h0;
  logic [13:0] pcTarget = 14'h0000;
  crf_pkg::crf_frame_t pullFrame = '0;
  logic [4:0] irqEvent = 5'h00;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic [9:0] ramAddr;
  logic [15:0] dPortSel;
  logic [3:0] accOut, secondOut, colIdxOut, rowIdxOut, colAuxOut, rowAuxOut;
  logic [1:0] pageOut;
  logic [23:0][3:0] initRegs;
  logic carryOut, statusOut, pushStrobe;
  logic [13:0] pcOut;
  logic [13:0] pcSeen;
  logic [9:0] spOut;
  crf_pkg::crf_frame_t pushFrame;
  int bad_count = 0;
  int checks = 0;

  always #5 mclk = ~mclk;

  crf_cpu_regs_flags_reset dut_u (.mclk(mclk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .opData(opData), .aluCarry(aluCarry), .aluStatus(aluStatus), .opBit(opBit),
    .pcTarget(pcTarget), .pullFrame(pullFrame), .irqEvent(irqEvent), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .accOut(accOut), .secondOut(secondOut), .pageOut(pageOut), .colIdxOut(colIdxOut),
    .rowIdxOut(rowIdxOut), .colAuxOut(colAuxOut), .rowAuxOut(rowAuxOut),
    .ramAddr(ramAddr), .dPortSel(dPortSel), .carryOut(carryOut), .statusOut(statusOut),
    .pcOut(pcOut), .fetchEn(), .spOut(spOut), .pushStrobe(pushStrobe), .pushFrame(pushFrame),
    .irqEnable(), .irqFlags(), .irqMasks(), .initRegs(initRegs));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // x doubles as pulled frame, target pc and alu flags to keep calls short
  task automatic op(input crf_pkg::crf_op_t c, input logic [3:0] d = 4'h0,
                    input logic [15:0] x = 16'h0000);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= c;
    opData <= d;
    opBit <= d;
    pullFrame <= x;
    pcTarget <= x[15:2];
    {aluCarry, aluStatus} <= x[1:0];
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask : rd

  task automatic reset_pulse;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask : reset_pulse

  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    reset_pulse();
    rd(8'h07, 16'h0002);
    rd(8'h09, 16'h03FF);
    rd(8'h0A, 16'h07C0);
    for (int i = 0; i < 24; i++)
      if (i != 15 && i != 21) rd(8'h20 + 8'(i), (i < 3) ? 16'h000F : 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wr(8'(i), 16'hFFF0 + 16'(i + 9));
      rd(8'(i), 16'(i + 9) & ((i == 2) ? 16'h0003 : 16'h000F));
    end
    wr(8'h08, 16'h1234);
    rd(8'h08, 16'h0000);
    rd(8'h40, 16'h0000);
    op(crf_pkg::OP_LD_W, 4'h2);
    op(crf_pkg::OP_LD_X, 4'h5);
    op(crf_pkg::OP_LD_Y, 4'h9);
    chk(16'(ramAddr), 16'h0259);
    chk(dPortSel, 16'h0200);
    op(crf_pkg::OP_LD_B, 4'h6);
    op(crf_pkg::OP_LD_SPY, 4'h4);
    op(crf_pkg::OP_XCH_Y);
    op(crf_pkg::OP_LD_SPX, 4'h3);
    op(crf_pkg::OP_XCH_X);
    rd(8'h03, 16'h0003);
    rd(8'h05, 16'h0005);
    chk(16'({colIdxOut, colAuxOut, rowIdxOut, rowAuxOut}), 16'h3549);
    chk(16'({accOut, secondOut, 2'b00, pageOut}), 16'h0962);
    op(crf_pkg::OP_ARITH, 4'h9, 16'h0001);
    op(crf_pkg::OP_ROTATE_LEFT_INSTR);
    chk(16'(carryOut), 16'h0001);
    rd(8'h00, 16'h0002);
    op(crf_pkg::OP_ROTATE_RIGHT_INSTR);
    chk(16'(carryOut), 16'h0000);
    rd(8'h00, 16'h0009);
    op(crf_pkg::OP_SEC);
    chk(16'(carryOut), 16'h0001);
    op(crf_pkg::OP_REC);
    chk(16'(carryOut), 16'h0000);
    op(crf_pkg::OP_ARITH, 4'h0, 16'h0002);
    chk(16'({carryOut, statusOut}), 16'h0002);
    op(crf_pkg::OP_SEC);
    chk(16'(statusOut), 16'h0000);
    op(crf_pkg::OP_TEST, 4'h0, 16'h0001);
    chk(16'(statusOut), 16'h0001);
    op(crf_pkg::OP_CMP);
    chk(16'(statusOut), 16'h0000);
    pcSeen = pcOut;
    op(crf_pkg::OP_BRANCH, 4'h0, 16'h48D0);
    chk(16'({pcOut, statusOut}), 16'({pcSeen + 14'h0001, 1'b1}));
    pcSeen = pcOut;
    op(crf_pkg::OP_CALL, 4'h0, 16'h48D0);
    chk(16'(pcOut), 16'h1234);
    chk(16'({spOut, pushStrobe}), 16'h07F7);
    chk(pushFrame, {pcSeen + 14'h0001, 2'b11});
    op(crf_pkg::OP_IRQ, 4'h0, 16'h0100);
    chk(pushFrame, 16'h48D3);
    chk(16'(spOut), 16'h03F7);
    op(crf_pkg::OP_RETURN_FROM_INTERRUPT, 4'h0, 16'h48D4);
    chk(16'({pcOut, carryOut, statusOut}), 16'h48D4);
    chk(16'(spOut), 16'h03FB);
    op(crf_pkg::OP_RTN, 4'h0, 16'h0403);
    chk(16'({carryOut, statusOut}), 16'h0000);
    chk(16'(spOut), 16'h03FF);
    op(crf_pkg::OP_JUMP, 4'h0, 16'h2468);
    chk(16'(pcOut), 16'h091A);
    op(crf_pkg::OP_IRQ, 4'h0, 16'h0100);
    op(crf_pkg::OP_REM, 4'hB);
    chk(16'(spOut), 16'h03FF);
    op(crf_pkg::OP_SEM, 4'h0);
    op(crf_pkg::OP_SEM, 4'h1);
    rd(8'h0A, 16'h07C1);
    op(crf_pkg::OP_TM, 4'h0);
    chk(16'(statusOut), 16'h0001);
    wr(8'h0A, 16'h003E);
    rd(8'h0A, 16'h0000);
    @(posedge mclk);
    irqEvent <= 5'h01;
    @(posedge mclk);
    irqEvent <= 5'h00;
    rd(8'h0A, 16'h0002);
    op(crf_pkg::OP_REM, 4'h1);
    rd(8'h0A, 16'h0000);
    wr(8'h2E, 16'h0005);
    rd(8'h2E, 16'h0005);
    chk(16'(initRegs[14]), 16'h0005);
    @(posedge mclk);
    reset_pulse();
    #1;
    chk(16'({pcOut, statusOut}), 16'h0001);
    chk(16'(initRegs[14]), 16'h0000);
    rd(8'h0A, 16'h07C0);
    rd(8'h09, 16'h03FF);
    tally_and_finish();
  end
endmodule : crf_cpu_regs_flags_reset_tb

`default_nettype wire
